//--- include/pss_consts.vh
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
// register offsets
`define PSS_OFS_PCON      4'h0
`define PSS_OFS_PDCFG     4'h1
`define PSS_OFS_WAKECFG   4'h2
`define PSS_OFS_RTCPRE    4'h3
`define PSS_OFS_RTCCNT    4'h4
`define PSS_OFS_STATUS    4'h5
`define PSS_OFS_GPREG0    4'h8
`define PSS_NUM_GPREG     5
// power control fields
`define PSS_PC_DPD_SEL    0
`define PSS_PC_SLEEP_FLG  1
`define PSS_PC_DPD_FLG    2
`define PSS_PC_FORCE_BAT  3
`define PSS_PC_FORCE_FLD  4
`define PSS_PC_BOD_EN     5
// wake config fields
`define PSS_WC_PIN_EN     0
`define PSS_WC_RF_EN      1
// start logic
`define PSS_SL_W          13
`define PSS_SL_RF         11
`define PSS_SL_RTC        12
`define PSS_PDCFG_W       8
`define PSS_PDCFG_RST     8'hFF
// irq lines
`define PSS_IRQ_FIELD     17
`define PSS_IRQ_BOD       19
// sequencer states
`define PSS_ST_OFF        3'h0
`define PSS_ST_DIGUP      3'h1
`define PSS_ST_ANAUP      3'h2
`define PSS_ST_BOOTW      3'h3
`define PSS_ST_ACTIVE     3'h4
`define PSS_ST_SLEEP      3'h5
`define PSS_ST_DPD        3'h6
// timing, 32.768 kHz timer oscillator
`define PSS_CLK_HZ        32768
`define PSS_SEQ_US        2500
`define PSS_STEP_CYC      ((`PSS_SEQ_US * `PSS_CLK_HZ / 1000000) / 3)
`define PSS_WAKE_PIN_US   100
`define PSS_WAKE_PIN_CYC  (((`PSS_WAKE_PIN_US * `PSS_CLK_HZ + 999999) / 1000000))
`define PSS_CNT_W         8
`endif

//--- logic/pss_power_state_sequencer.v
// Operation
// - digital and analog regulators enabled independently
// - four power states with mode flags
// - power-on reset on battery or field power
// - timer oscillator starts the sequencer
// - first step enables digital regulator
// - second step enables analog regulator, flash
// - system reset released after regulator, oscillator
// - boot held until flash ready
// - whole sequence about 2.5 ms
// - timer oscillator cannot be disabled
// - deep-sleep wake sources
// - deep power-down wake sources, reduced set
// - rf wake only when configured
// - timer wake at preset value
// - five retained general-purpose registers
// - brownout interrupt when enabled
// - power-down config switches analog slaves
// - control selects sleep or deep power-down
// - flags show sleep and power-down entered
// - overrides force battery or field switch
// - start-logic lines map pins, rf, timer
// - field power line 17, brownout 19
// - close battery switch on reset rising edge
//
// Local design decisions: strobed register access and the address map.
`include "pss_consts.vh"
module pss_power_state_sequencer (
    // clock (timer oscillator) and always-on reset
    input  wire                    sys_clk,
    input  wire                    reset,
    // register port
    input  wire [3:0]              reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata,
    // core and analog status
    input  wire                    core_lp_req,
    input  wire                    sysosc_stable,
    input  wire                    flash_ready,
    input  wire                    battery_ok,
    input  wire                    field_supply,
    input  wire                    brownout_detector,
    // wake sources
    input  wire                    external_reset_pin,
    input  wire                    wakeup_pin,
    input  wire                    rf_detect,
    input  wire                    watchdog_event,
    input  wire [10:0]             port_pins,
    input  wire [`PSS_SL_W-1:0]    start_enable,
    // power outputs
    output reg                     digital_regulator,
    output reg                     analog_regulator,
    output reg                     battery_switch,
    output reg                     field_switch,
    output reg                     system_por,
    output reg                     boot_enable,
    output reg                     timer_oscillator,
    output reg                     deep_powerdown_flag,
    output reg                     sleep_flag,
    output reg  [`PSS_PDCFG_W-1:0] analog_power_down,
    output reg  [31:0]             irq_lines
);
    // two-flop synchronisers for all pins
    reg [15:0] s1_q;
    reg [15:0] s2_q;
    wire [15:0] raw_in = {brownout_detector, external_reset_pin, wakeup_pin, rf_detect,
                          field_supply, port_pins};
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
        end
    end
    wire [10:0] pins_s  = s2_q[10:0];
    wire        fld_s   = s2_q[11];
    wire        rf_s    = s2_q[12];
    wire        wkp_s   = s2_q[13];
    wire        rstp_s  = s2_q[14];
    wire        bod_s   = s2_q[15];

    reg                     rstp_q;
    reg  [2:0]              st_q;
    reg  [`PSS_CNT_W-1:0]   cnt_q;
    reg  [`PSS_CNT_W-1:0]   wkcnt_q;
    reg                     dpd_sel_q;
    reg                     force_bat_q;
    reg                     force_fld_q;
    reg                     bod_en_q;
    reg                     pin_en_q;
    reg                     rf_en_q;
    reg  [31:0]             rtc_pre_q;
    reg  [31:0]             rtc_cnt_q;
    reg  [31:0]             gpreg_q [0:`PSS_NUM_GPREG-1];
    integer i;
    // separate loop index for the read mux, so each process owns its own
    integer j;

    wire rstp_rise = rstp_s & ~rstp_q;
    wire rtc_hit   = (rtc_cnt_q == rtc_pre_q) & (rtc_pre_q != 32'h0000_0000);
    wire rf_wake   = rf_s & rf_en_q;
    // short low glitches on the wake pin do not end power-down
    wire pin_dpd   = pin_en_q & (wkcnt_q >= `PSS_WAKE_PIN_CYC);
    wire [`PSS_SL_W-1:0] start_src = {rtc_hit, rf_wake, pins_s};
    wire start_wake = |(start_src & start_enable);
    wire wake_ds  = rstp_rise | rtc_hit | watchdog_event | wkp_s | rf_wake
                    | start_wake;
    wire wake_dpd = rstp_rise | rtc_hit | pin_dpd | rf_wake;
    wire powered  = battery_switch | field_switch;

    // battery switch latches closed on reset pin rising edge
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rstp_q         <= 1'b0;
            battery_switch <= 1'b0;
            field_switch   <= 1'b0;
        end else begin
            rstp_q <= rstp_s;
            if (force_bat_q) begin
                battery_switch <= 1'b1;
                field_switch   <= 1'b0;
            end else if (force_fld_q) begin
                battery_switch <= 1'b0;
                field_switch   <= fld_s;
            end else begin
                if (rstp_rise & battery_ok)
                    battery_switch <= 1'b1;
                else if (!battery_ok)
                    battery_switch <= 1'b0;
                // field supplies only when the battery switch is open or battery_ok is low
                field_switch <= fld_s & ~(battery_switch & battery_ok);
            end
        end
    end

    // wake pin low-time counter, saturating
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            wkcnt_q <= {`PSS_CNT_W{1'b0}};
        else if (wkp_s | st_q != `PSS_ST_DPD)
            wkcnt_q <= {`PSS_CNT_W{1'b0}};
        else if (wkcnt_q != {`PSS_CNT_W{1'b1}})
            wkcnt_q <= wkcnt_q + 1'b1;
    end

    // sequencer; reset is the always-on power-on reset
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q                <= `PSS_ST_OFF;
            cnt_q               <= {`PSS_CNT_W{1'b0}};
            digital_regulator   <= 1'b0;
            analog_regulator    <= 1'b0;
            system_por          <= 1'b1;
            boot_enable         <= 1'b0;
            deep_powerdown_flag <= 1'b0;
            sleep_flag          <= 1'b0;
        end else begin
            case (st_q)
                `PSS_ST_OFF: begin
                    digital_regulator <= 1'b0;
                    analog_regulator  <= 1'b0;
                    system_por        <= 1'b1;
                    boot_enable       <= 1'b0;
                    cnt_q             <= {`PSS_CNT_W{1'b0}};
                    // mode flags mean nothing once the supply is gone
                    sleep_flag          <= 1'b0;
                    deep_powerdown_flag <= 1'b0;
                    if (powered)
                        st_q <= `PSS_ST_DIGUP;
                end
                `PSS_ST_DIGUP: begin
                    digital_regulator <= 1'b1;
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q >= `PSS_STEP_CYC - 1) begin
                        cnt_q <= {`PSS_CNT_W{1'b0}};
                        st_q  <= `PSS_ST_ANAUP;
                    end
                end
                `PSS_ST_ANAUP: begin
                    analog_regulator <= 1'b1;
                    if (digital_regulator & sysosc_stable)
                        system_por <= 1'b0;
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q >= `PSS_STEP_CYC - 1) begin
                        cnt_q <= {`PSS_CNT_W{1'b0}};
                        st_q  <= `PSS_ST_BOOTW;
                    end
                end
                `PSS_ST_BOOTW: begin
                    if (sysosc_stable)
                        system_por <= 1'b0;
                    cnt_q <= (cnt_q >= `PSS_STEP_CYC - 1) ? cnt_q : cnt_q + 1'b1;
                    if (flash_ready & ~system_por & cnt_q >= `PSS_STEP_CYC - 1) begin
                        boot_enable         <= 1'b1;
                        deep_powerdown_flag <= 1'b0;
                        st_q                <= `PSS_ST_ACTIVE;
                    end
                end
                `PSS_ST_ACTIVE: begin
                    sleep_flag          <= 1'b0;
                    deep_powerdown_flag <= 1'b0;
                    if (core_lp_req) begin
                        if (dpd_sel_q) begin
                            st_q                <= `PSS_ST_DPD;
                            deep_powerdown_flag <= 1'b1;
                            // regulators drop with the flag, never after it
                            digital_regulator   <= 1'b0;
                            analog_regulator    <= 1'b0;
                            system_por          <= 1'b1;
                            boot_enable         <= 1'b0;
                        end else begin
                            st_q       <= `PSS_ST_SLEEP;
                            sleep_flag <= 1'b1;
                        end
                    end
                end
                `PSS_ST_SLEEP: begin
                    if (wake_ds)
                        st_q <= `PSS_ST_ACTIVE;
                end
                `PSS_ST_DPD: begin
                    digital_regulator <= 1'b0;
                    analog_regulator  <= 1'b0;
                    system_por        <= 1'b1;
                    boot_enable       <= 1'b0;
                    cnt_q             <= {`PSS_CNT_W{1'b0}};
                    if (wake_dpd) begin
                        st_q                <= `PSS_ST_DIGUP;
                        // flag leaves before the regulators come back
                        deep_powerdown_flag <= 1'b0;
                    end
                end
                default: st_q <= `PSS_ST_OFF;
            endcase
            if (!powered)
                st_q <= `PSS_ST_OFF;
        end
    end

    // timer oscillator always runs; no register bit reaches it
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            timer_oscillator <= 1'b1;
        else
            timer_oscillator <= 1'b1;
    end

    // interrupt lines to the core
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            irq_lines <= 32'h0000_0000;
        else begin
            irq_lines <= 32'h0000_0000;
            irq_lines[`PSS_SL_W-1:0]   <= start_src & start_enable;
            irq_lines[`PSS_IRQ_FIELD]  <= fld_s;
            irq_lines[`PSS_IRQ_BOD]    <= bod_s & bod_en_q;
        end
    end

    // registers; retained ones live in the always-on domain
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dpd_sel_q         <= 1'b0;
            force_bat_q       <= 1'b0;
            force_fld_q       <= 1'b0;
            bod_en_q          <= 1'b0;
            pin_en_q          <= 1'b0;
            rf_en_q           <= 1'b0;
            rtc_pre_q         <= 32'h0000_0000;
            rtc_cnt_q         <= 32'h0000_0000;
            analog_power_down <= `PSS_PDCFG_RST;
            for (i = 0; i < `PSS_NUM_GPREG; i = i + 1)
                gpreg_q[i] <= 32'h0000_0000;
        end else begin
            rtc_cnt_q <= rtc_hit ? 32'h0000_0000 : rtc_cnt_q + 32'h0000_0001;
            if (reg_wr) begin
                case (reg_addr)
                    `PSS_OFS_PCON: begin
                        dpd_sel_q   <= reg_wdata[`PSS_PC_DPD_SEL];
                        force_bat_q <= reg_wdata[`PSS_PC_FORCE_BAT];
                        force_fld_q <= reg_wdata[`PSS_PC_FORCE_FLD];
                        bod_en_q    <= reg_wdata[`PSS_PC_BOD_EN];
                    end
                    `PSS_OFS_PDCFG: analog_power_down <= reg_wdata[`PSS_PDCFG_W-1:0];
                    `PSS_OFS_WAKECFG: begin
                        pin_en_q <= reg_wdata[`PSS_WC_PIN_EN];
                        rf_en_q  <= reg_wdata[`PSS_WC_RF_EN];
                    end
                    `PSS_OFS_RTCPRE: begin
                        rtc_pre_q <= reg_wdata;
                        // restart, else a preset below the count waits a full wrap
                        rtc_cnt_q <= 32'h0000_0000;
                    end
                    default: begin
                        for (i = 0; i < `PSS_NUM_GPREG; i = i + 1)
                            if (reg_addr == `PSS_OFS_GPREG0 + i)
                                gpreg_q[i] <= reg_wdata;
                    end
                endcase
            end
        end
    end

    // read data one cycle after the strobe
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (reg_addr)
            `PSS_OFS_PCON: begin
                rd_d[`PSS_PC_DPD_SEL]   = dpd_sel_q;
                rd_d[`PSS_PC_SLEEP_FLG] = sleep_flag;
                rd_d[`PSS_PC_DPD_FLG]   = deep_powerdown_flag;
                rd_d[`PSS_PC_FORCE_BAT] = force_bat_q;
                rd_d[`PSS_PC_FORCE_FLD] = force_fld_q;
                rd_d[`PSS_PC_BOD_EN]    = bod_en_q;
            end
            `PSS_OFS_PDCFG:   rd_d[`PSS_PDCFG_W-1:0] = analog_power_down;
            `PSS_OFS_WAKECFG: rd_d[1:0] = {rf_en_q, pin_en_q};
            `PSS_OFS_RTCPRE:  rd_d = rtc_pre_q;
            `PSS_OFS_RTCCNT:  rd_d = rtc_cnt_q;
            `PSS_OFS_STATUS:  rd_d[4:0] = {field_switch, battery_switch, st_q};
            default: begin
                for (j = 0; j < `PSS_NUM_GPREG; j = j + 1)
                    if (reg_addr == `PSS_OFS_GPREG0 + j)
                        rd_d = gpreg_q[j];
            end
        endcase
    end
    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
    end
endmodule // pss_power_state_sequencer

//--- sim/pss_partner.sv
module pss_partner #(
    parameter int OSC_DLY   = 6,
    parameter int FLASH_DLY = 40
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // bench request
    input  wire logic lp_go,
    // device outputs
    input  wire logic digital_regulator,
    input  wire logic analog_regulator,
    input  wire logic sleep_flag,
    input  wire logic deep_powerdown_flag,
    // core and analog status
    output logic      core_lp_req,
    output logic      sysosc_stable,
    output logic      flash_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int osc_cnt;
    int fl_cnt;
    // flash slower than one step, so the boot wait really waits
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            osc_cnt <= 0;
            fl_cnt <= 0;
            core_lp_req <= 1'b0;
            sysosc_stable <= 1'b0;
            flash_ready <= 1'b0;
        end else begin
            osc_cnt <= digital_regulator ? osc_cnt + 1 : 0;
            fl_cnt <= analog_regulator ? fl_cnt + 1 : 0;
            sysosc_stable <= digital_regulator && osc_cnt >= OSC_DLY;
            flash_ready <= analog_regulator && fl_cnt >= FLASH_DLY;
            // core drops its request once a low-power flag shows
            if (sleep_flag || deep_powerdown_flag)
                core_lp_req <= 1'b0;
            else if (lp_go)
                core_lp_req <= 1'b1;
        end
    end
endmodule // pss_partner

//--- sim/pss_properties.sv
`include "pss_consts.vh"
module pss_properties (
    // clock and reset
    input wire logic                    sys_clk,
    input wire logic                    reset,
    // register port
    input wire logic [3:0]              reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic                    reg_wr,
    // far side status
    input wire logic                    sysosc_stable,
    input wire logic                    flash_ready,
    input wire logic                    field_supply,
    // power outputs
    input wire logic                    digital_regulator,
    input wire logic                    analog_regulator,
    input wire logic                    system_por,
    input wire logic                    boot_enable,
    input wire logic                    timer_oscillator,
    input wire logic                    deep_powerdown_flag,
    input wire logic                    sleep_flag,
    input wire logic [`PSS_PDCFG_W-1:0] analog_power_down,
    input wire logic [31:0]             irq_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_osc_on; timer_oscillator; endproperty
    a_osc_on: assert property (p_osc_on) else $error("timer oscillator off");
    property p_dpd_off; deep_powerdown_flag |-> !digital_regulator && !analog_regulator; endproperty
    a_dpd_off: assert property (p_dpd_off) else $error("regulator on in power-down");
    property p_sleep_on; sleep_flag |-> digital_regulator && analog_regulator; endproperty
    a_sleep_on: assert property (p_sleep_on) else $error("regulator off in sleep");
    property p_ana_late; $rose(analog_regulator) |-> $past(digital_regulator, 20); endproperty
    a_ana_late: assert property (p_ana_late) else $error("analog before digital");
    property p_por_osc; $fell(system_por) |-> digital_regulator && $past(sysosc_stable); endproperty
    a_por_osc: assert property (p_por_osc) else $error("por released early");
    property p_boot; $rose(boot_enable) |-> !system_por && $past(flash_ready); endproperty
    a_boot: assert property (p_boot) else $error("boot before flash");
    property p_pdcfg;
        reg_wr && reg_addr == `PSS_OFS_PDCFG |=>
            analog_power_down == $past(reg_wdata[`PSS_PDCFG_W-1:0]);
    endproperty
    a_pdcfg: assert property (p_pdcfg) else $error("power-down config lost");
    property p_fld_irq; field_supply [*5] |-> irq_lines[`PSS_IRQ_FIELD]; endproperty
    a_fld_irq: assert property (p_fld_irq) else $error("field line missing");
    property p_irq_free; irq_lines[16:13] == 4'h0 && !irq_lines[18]; endproperty
    a_irq_free: assert property (p_irq_free) else $error("foreign irq line");
    c_sleep: cover property ($rose(sleep_flag));
    c_dpd: cover property ($rose(deep_powerdown_flag));
    c_boot: cover property ($rose(boot_enable));
endmodule // pss_properties

bind pss_power_state_sequencer pss_properties i_pss_properties (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .sysosc_stable(sysosc_stable), .flash_ready(flash_ready),
    .field_supply(field_supply), .digital_regulator(digital_regulator),
    .analog_regulator(analog_regulator), .system_por(system_por),
    .boot_enable(boot_enable), .timer_oscillator(timer_oscillator),
    .deep_powerdown_flag(deep_powerdown_flag), .sleep_flag(sleep_flag),
    .analog_power_down(analog_power_down), .irq_lines(irq_lines)
);

//--- sim/test_power_state_sequencer.sv
`include "pss_consts.vh"
module test_power_state_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = `PSS_STEP_CYC;
    logic        sys_clk, reset, reg_wr, reg_rd, lp_go, core_lp_req, sysosc_stable, flash_ready;
    logic        battery_ok, field_supply, brownout_detector, external_reset_pin, wakeup_pin;
    logic        rf_detect, watchdog_event, digital_regulator, analog_regulator, battery_switch;
    logic        field_switch, system_por, boot_enable, timer_oscillator;
    logic        deep_powerdown_flag, sleep_flag;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, irq_lines;
    logic [10:0] port_pins;
    logic [`PSS_SL_W-1:0]    start_enable;
    logic [`PSS_PDCFG_W-1:0] analog_power_down;
    int          err_total, cmp_count, n;

    pss_power_state_sequencer i_pss_power_state_sequencer (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_lp_req(core_lp_req),
        .sysosc_stable(sysosc_stable), .flash_ready(flash_ready), .battery_ok(battery_ok),
        .field_supply(field_supply), .brownout_detector(brownout_detector),
        .external_reset_pin(external_reset_pin), .wakeup_pin(wakeup_pin),
        .rf_detect(rf_detect), .watchdog_event(watchdog_event), .port_pins(port_pins),
        .start_enable(start_enable), .digital_regulator(digital_regulator),
        .analog_regulator(analog_regulator), .battery_switch(battery_switch),
        .field_switch(field_switch), .system_por(system_por), .boot_enable(boot_enable),
        .timer_oscillator(timer_oscillator), .deep_powerdown_flag(deep_powerdown_flag),
        .sleep_flag(sleep_flag), .analog_power_down(analog_power_down), .irq_lines(irq_lines)
    );
    pss_partner i_pss_partner (
        .sys_clk(sys_clk), .reset(reset), .lp_go(lp_go), .digital_regulator(digital_regulator),
        .analog_regulator(analog_regulator), .sleep_flag(sleep_flag),
        .deep_powerdown_flag(deep_powerdown_flag), .core_lp_req(core_lp_req),
        .sysosc_stable(sysosc_stable), .flash_ready(flash_ready)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // bounded wait, n holds the cycles spent
    task automatic wait_on(ref logic s, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (s !== v && n < lim);
        chk(s, v);
    endtask
    task automatic core_sleep();
        @(posedge sys_clk);
        lp_go <= 1'b1;
        @(posedge sys_clk);
        lp_go <= 1'b0;
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        err_total++;
        $display("unexpected at %0t: run hung", $time);
        stop_test();
    end
    initial begin
        {reset, battery_ok} = 2'b11;
        {reg_wr, reg_rd, lp_go, field_supply, brownout_detector, external_reset_pin} = '0;
        {wakeup_pin, rf_detect, watchdog_event, reg_addr, reg_wdata, port_pins} = '0;
        start_enable = 13'h0008;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1 chk(timer_oscillator, 1'b1);
        chk(analog_power_down, `PSS_PDCFG_RST);
        chk({digital_regulator, analog_regulator, system_por, battery_switch}, 4'h2);
        @(posedge sys_clk);
        external_reset_pin <= 1'b1;
        wait_on(digital_regulator, 1'b1, 10);
        wait_on(analog_regulator, 1'b1, 60);
        chk(n >= STEP - 1, 1'b1);
        wait_on(boot_enable, 1'b1, 400);
        chk({system_por, battery_switch}, 2'b01);
        rd(`PSS_OFS_STATUS, 32'h0C);
        rd(`PSS_OFS_PCON, 32'h0);
        rd(4'h6, 32'h0);
        wr(`PSS_OFS_PDCFG, 32'h5A);
        rd(`PSS_OFS_PDCFG, 32'h5A);
        chk(analog_power_down, 8'h5A);
        for (int i = 0; i < `PSS_NUM_GPREG; i++)
            wr(`PSS_OFS_GPREG0 + i, 32'hC0DE0000 + i);
        for (int k = 0; k < 5; k++) begin
            wr(`PSS_OFS_WAKECFG, (k == 3) ? 32'h2 : 32'h0);
            core_sleep();
            wait_on(sleep_flag, 1'b1, 20);
            rd(`PSS_OFS_PCON, 32'h2);
            @(posedge sys_clk);
            // rf must not wake while its option is off
            rf_detect <= (k == 0);
            repeat (12) @(posedge sys_clk);
            #1 chk(sleep_flag, 1'b1);
            @(posedge sys_clk);
            case (k)
                0: watchdog_event <= 1'b1;
                1: wakeup_pin <= 1'b1;
                2: port_pins <= 11'h008;
                3: rf_detect <= 1'b1;
                default: wr(`PSS_OFS_RTCPRE, 32'h10);
            endcase
            wait_on(sleep_flag, 1'b0, 40);
            if (k == 2)
                chk(irq_lines[3], 1'b1);
            @(posedge sys_clk);
            {watchdog_event, wakeup_pin, rf_detect, port_pins} <= '0;
            repeat (6) @(posedge sys_clk);
        end
        wr(`PSS_OFS_RTCPRE, 32'h0);
        wr(`PSS_OFS_WAKECFG, 32'h1);
        wr(`PSS_OFS_PCON, 32'h1);
        @(posedge sys_clk);
        wakeup_pin <= 1'b1;
        core_sleep();
        wait_on(deep_powerdown_flag, 1'b1, 20);
        chk({digital_regulator, analog_regulator}, 2'b00);
        @(posedge sys_clk);
        watchdog_event <= 1'b1;
        port_pins <= 11'h008;
        repeat (12) @(posedge sys_clk);
        #1 chk(deep_powerdown_flag, 1'b1);
        @(posedge sys_clk);
        {watchdog_event, port_pins, wakeup_pin} <= '0;
        wait_on(digital_regulator, 1'b1, 20);
        chk(analog_regulator, 1'b0);
        @(posedge sys_clk);
        wakeup_pin <= 1'b1;
        wait_on(boot_enable, 1'b1, 400);
        for (int i = 0; i < `PSS_NUM_GPREG; i++)
            rd(`PSS_OFS_GPREG0 + i, 32'hC0DE0000 + i);
        @(posedge sys_clk);
        field_supply <= 1'b1;
        repeat (6) @(posedge sys_clk);
        // battery already closed, so it keeps priority over the field switch
        #1 chk({irq_lines[`PSS_IRQ_FIELD], field_switch}, 2'b10);
        wr(`PSS_OFS_PCON, 32'h20);
        brownout_detector <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 chk(irq_lines[`PSS_IRQ_BOD], 1'b1);
        wr(`PSS_OFS_PCON, 32'h10);
        repeat (6) @(posedge sys_clk);
        #1 chk({field_switch, battery_switch}, 2'b10);
        wr(`PSS_OFS_PCON, 32'h08);
        repeat (6) @(posedge sys_clk);
        #1 chk(battery_switch, 1'b1);
        stop_test();
    end
endmodule // test_power_state_sequencer
